// ===== src/ietu_edge_filter.sv
// qualified edge filter: reports an edge once the new level lasts long enough
// after the old level lasted long enough; input is synchronous to clk
`include "ietu_params.svh"
module ietu_edge_filter
  import ietu_pkg::*;
#(
  parameter int OLD_MIN  = 4,
  parameter int NEW_MIN  = 4,
  parameter bit RISING   = 1'b1
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clkEn,
  input  wire logic pinIn,
  output logic      edgeSeen
);
  ietu_filt_type state_q, state_d;
  logic          oldLvl;

  always_comb begin
    oldLvl  = ~RISING;
    state_d = state_q;
    edgeSeen = 1'b0;
    state_d.prev = pinIn;
    if (pinIn == oldLvl) begin
      state_d.lowCnt = 4'h0;
      state_d.armed  = 1'b0;
      if (state_q.highCnt != 4'hF) begin
        state_d.highCnt = state_q.highCnt + 4'h1;
      end
    end else begin
      // new level: armed only if old level lasted more than OLD_MIN
      if (state_q.prev == oldLvl) begin
        state_d.armed = (state_q.highCnt > 4'(OLD_MIN));
        state_d.lowCnt = 4'h1;
      end else if (state_q.lowCnt != 4'hF) begin
        state_d.lowCnt = state_q.lowCnt + 4'h1;
      end
      if (state_q.armed && state_q.lowCnt == 4'(NEW_MIN)) begin
        edgeSeen      = 1'b1;
        state_d.armed = 1'b0;
      end
      state_d.highCnt = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= '{highCnt: 4'h0, lowCnt: 4'h0, armed: 1'b0, prev: 1'b1};
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end
endmodule : ietu_edge_filter

// ===== src/ietu_params.svh
// constants of the interrupt and event timer unit: vectors, status word layout, timing counts
// assumes a 50 MHz clk; one machine cycle is 30 clocks as in the core it serves
`ifndef IETU_PARAMS_SVH
`define IETU_PARAMS_SVH
`define IETU_VEC_EXT        13'h0003
`define IETU_VEC_SER        13'h0005
`define IETU_VEC_TMR        13'h0007
`define IETU_PSW_PS_BIT     3
`define IETU_PSW_RBS_BIT    4
`define IETU_PSW_ONE_BIT    5
`define IETU_PSW_AC_BIT     6
`define IETU_PSW_CY_BIT     7
`define IETU_PSW_RESET      8'h20
`define IETU_MCYCLE_CLKS    30
`define IETU_PRESCALE_DIV   32
`define IETU_EXT_HIGH_MIN   4
`define IETU_EXT_LOW_MIN    7
`define IETU_CNT_LEVEL_MIN  4
`define IETU_CNT_LOAD       8'hFF
`endif

// ===== src/ietu_pkg.sv
// types of the interrupt and event timer unit
// used by ietu_top and ietu_edge_filter
package ietu_pkg;
  typedef enum logic [1:0] {
    IETU_CNT_OFF   = 2'b00,
    IETU_CNT_TIMER = 2'b01,
    IETU_CNT_EVENT = 2'b10
  } ietu_cnt_mode_type;

  typedef enum logic [3:0] {
    IETU_OP_NONE      = 4'h0,
    IETU_OP_TSTART    = 4'h1,
    IETU_OP_CSTART    = 4'h2,
    IETU_OP_HALT      = 4'h3,
    IETU_OP_EXT_EN    = 4'h4,
    IETU_OP_EXT_DIS   = 4'h5,
    IETU_OP_TMR_EN    = 4'h6,
    IETU_OP_TMR_DIS   = 4'h7,
    IETU_OP_SER_EN    = 4'h8,
    IETU_OP_SER_DIS   = 4'h9,
    IETU_OP_INTERRUPT_EXIT_OP      = 4'hA,
    IETU_OP_RET       = 4'hB,
    IETU_OP_CALL      = 4'hC,
    IETU_OP_JMP       = 4'hD,
    IETU_OP_BANKSEL   = 4'hE
  } ietu_op_type;

  typedef struct packed {
    logic [3:0] highCnt;
    logic [3:0] lowCnt;
    logic       armed;
    logic       prev;
  } ietu_filt_type;
endpackage : ietu_pkg

// ===== src/ietu_top.sv
// interrupt control, status word, program counter banking and timer/event counter
// assumes the core issues one op per clock and marks instruction boundaries
// Notes on behaviour
// [RQ1] pc is 13 bits, low 11 increment, top 2 set by preselect then jump/call
// [RQ2] status word: stack level 0-2, prescale 3, bank 4, one 5, half carry 6, carry 7
// [RQ3] stack level by call/return/interrupt, bit3 by move, bit4 by bank op, bit6 by add
// [RQ4] single level interrupts; requests arriving meanwhile stay latched
// [RQ5] priority: external, then serial/derivative, then timer
// [RQ6] a request is recognised only while its enable is set
// [RQ7] interrupt pushes pc and status bits 4,6,7 then loads vector
// [RQ8] vectors: external 3, serial/derivative 5, timer 7
// [RQ9] interrupt exit clears active flag; one main instruction runs before next
// [RQ10] while active, pc top two bits are forced to zero
// [RQ11] external falling edge latched after low over 7 clocks following high over 4
// [RQ12] latched edge sets external flag when enabled; cleared by vector or disable
// [RQ13] test branches use sampled pins; test a only while external irq disabled
// [RQ14] shared active-low request line is driven by serial/derivative logic
// [RQ15] overflow sets timer request when enabled; cleared by vector or disable
// [RQ16] event start loads all ones so next edge overflows
// [RQ17] 8-bit up counter, preset and read by instructions
// [RQ18] timer mode counts each machine cycle or every 32
// [RQ19] timer start clears prescaler, the only access to it
// [RQ20] event edge qualified by levels over 4 clocks; at most one count per machine cycle
// [RQ21] counting inhibited after reset and by halt op
// [RQ22] each overflow sets overflow flag unless its test branch runs in that cycle; cleared only by that test branch or reset
// [RQ23] stack level points to next free level, wraps 7 to 0
// [RQ24] interrupts taken only at instruction boundaries
`include "ietu_params.svh"
module ietu_top
  import ietu_pkg::*;
#(
  parameter int MCYCLE_CLKS = `IETU_MCYCLE_CLKS,
  parameter int PRESCALE    = `IETU_PRESCALE_DIV
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  input  wire logic        irqTestAInput,
  input  wire logic        countTestBInput,
  input  wire logic        serialIrqN,
  input  wire ietu_op_type opCode,
  input  wire logic        instrBoundary,
  input  wire logic        pcIncrement,
  input  wire logic [10:0] jumpTarget,
  input  wire logic        bankPreselect,
  input  wire logic [1:0]  bankValue,
  input  wire logic        pswWrite,
  input  wire logic [7:0]  accIn,
  input  wire logic        counterWrite,
  input  wire logic        bankSelValue,
  input  wire logic        addUpdate,
  input  wire logic        halfCarryIn,
  input  wire logic        carryIn,
  input  wire logic        carryUpdate,
  input  wire logic [2:0]  testSelect,
  input  wire logic        testInvert,
  input  wire logic [12:0] stackPcIn,
  input  wire logic [2:0]  stackPswIn,
  output logic [12:0]      programCounter,
  output logic [7:0]       processorStatusWord,
  output logic [7:0]       counterValue,
  output logic             stackPush,
  output logic [15:0]      stackPushData,
  output logic [2:0]       stackLevel,
  output logic             vectorCall,
  output logic             branchTaken,
  output logic             interruptActiveFlag,
  output logic             timerOverflowFlag
);
  typedef struct packed {
    logic [12:0]       pc;
    logic [1:0]        bankLatch;
    logic [2:0]        sp;
    logic              ps;
    logic              work_bank_choice;
    logic              ac;
    logic              cy;
    logic              interrupt_active_flag;
    logic              mainDone;
    logic              extEn;
    logic              serEn;
    logic              tmrEn;
    logic              extLatch;
    logic              extFlag;
    logic              tmrFlag;
    logic              ovfFlag;
    ietu_cnt_mode_type mode;
    logic [7:0]        count;
    logic [4:0]        mcDiv;
    logic [4:0]        pre;
    logic              evPend;
    logic              push;
    logic [15:0]       pushData;
    logic              vcall;
    logic              brTaken;
  } ietu_state_type;

  ietu_state_type s_q, s_d;
  logic extEdge, cntEdge, mcTick, incr, ovf;
  logic extReq, serReq, tmrReq;
  logic [12:0] vec;

  function automatic logic testPin(input logic [2:0] sel, input logic pa, input logic pb,
                                   input logic tf, input logic extOn);
    case (sel)
      3'h1:    testPin = pa & ~extOn;
      3'h2:    testPin = pb;
      3'h3:    testPin = tf;
      default: testPin = 1'b0;
    endcase
  endfunction : testPin

  ietu_edge_filter #(.OLD_MIN(`IETU_EXT_HIGH_MIN), .NEW_MIN(`IETU_EXT_LOW_MIN),
                     .RISING(1'b0)) uExtFilt (
    .clk      (clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .pinIn    (irqTestAInput),
    .edgeSeen (extEdge)  // see [RQ11]
  );

  ietu_edge_filter #(.OLD_MIN(`IETU_CNT_LEVEL_MIN), .NEW_MIN(`IETU_CNT_LEVEL_MIN),
                     .RISING(1'b1)) uCntFilt (
    .clk      (clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .pinIn    (countTestBInput),
    .edgeSeen (cntEdge)  // see [RQ20]
  );

  always_comb begin
    s_d = s_q;
    s_d.push = 1'b0;
    s_d.vcall = 1'b0;
    s_d.brTaken = 1'b0;
    vec = 13'h0000;
    mcTick = (s_q.mcDiv == 5'(MCYCLE_CLKS - 1));
    s_d.mcDiv = mcTick ? 5'h00 : s_q.mcDiv + 5'h01;
    // counter advance
    incr = 1'b0;
    if (cntEdge && s_q.mode == IETU_CNT_EVENT) begin
      s_d.evPend = 1'b1;
    end
    if (mcTick) begin
      if (s_q.mode == IETU_CNT_TIMER) begin  // see [RQ18]
        if (s_q.ps) begin
          incr = 1'b1;
        end else begin
          s_d.pre = (s_q.pre == 5'(PRESCALE - 1)) ? 5'h00 : s_q.pre + 5'h01;
          incr = (s_q.pre == 5'(PRESCALE - 1));
        end
      end else if (s_q.mode == IETU_CNT_EVENT && (s_q.evPend || cntEdge)) begin
        incr = 1'b1;  // see [RQ20]
        s_d.evPend = 1'b0;
      end
    end
    ovf = incr && (s_q.count == 8'hFF);
    if (incr) begin
      s_d.count = s_q.count + 8'h01;  // see [RQ17]
    end
    if (ovf) begin
      s_d.ovfFlag = 1'b1;  // see [RQ22]
      if (s_q.tmrEn) begin
        s_d.tmrFlag = 1'b1;  // see [RQ15]
      end
    end
    if (extEdge) begin
      s_d.extLatch = 1'b1;
    end
    if ((extEdge || s_q.extLatch) && s_q.extEn) begin
      s_d.extFlag = 1'b1;  // see [RQ12]
    end
    // pc auto increment, low 11 bits only
    if (pcIncrement) begin
      s_d.pc[10:0] = s_q.pc[10:0] + 11'h001;  // see [RQ1]
    end
    if (instrBoundary && !s_q.interrupt_active_flag) begin
      s_d.mainDone = 1'b1;
    end
    if (pswWrite) begin
      s_d.ps = accIn[`IETU_PSW_PS_BIT];  // see [RQ3]
    end
    if (addUpdate) begin
      s_d.ac = halfCarryIn;
    end
    if (carryUpdate) begin
      s_d.cy = carryIn;
    end
    if (counterWrite) begin
      s_d.count = accIn;
    end
    if (bankPreselect) begin
      s_d.bankLatch = bankValue;
    end
    case (opCode)
      IETU_OP_TSTART: begin
        s_d.mode = IETU_CNT_TIMER;
        s_d.pre = 5'h00;  // see [RQ19]
      end
      IETU_OP_CSTART: begin
        s_d.mode = IETU_CNT_EVENT;
        s_d.count = `IETU_CNT_LOAD;  // see [RQ16]
        s_d.evPend = 1'b0;
      end
      IETU_OP_HALT: begin
        s_d.mode = IETU_CNT_OFF;  // see [RQ21]
      end
      IETU_OP_EXT_EN: begin
        s_d.extEn = 1'b1;
      end
      IETU_OP_EXT_DIS: begin
        s_d.extEn = 1'b0;
        s_d.extLatch = 1'b0;
        s_d.extFlag = 1'b0;  // see [RQ12]
      end
      IETU_OP_TMR_EN: begin
        s_d.tmrEn = 1'b1;
      end
      IETU_OP_TMR_DIS: begin
        s_d.tmrEn = 1'b0;
        s_d.tmrFlag = 1'b0;  // see [RQ15]
      end
      IETU_OP_SER_EN: begin
        s_d.serEn = 1'b1;
      end
      IETU_OP_SER_DIS: begin
        s_d.serEn = 1'b0;
      end
      IETU_OP_INTERRUPT_EXIT_OP: begin
        s_d.sp = s_q.sp - 3'h1;
        s_d.pc = stackPcIn;
        s_d.work_bank_choice = stackPswIn[0];
        s_d.ac = stackPswIn[1];
        s_d.cy = stackPswIn[2];
        s_d.interrupt_active_flag = 1'b0;  // see [RQ9]
        s_d.mainDone = 1'b0;
      end
      IETU_OP_RET: begin
        s_d.sp = s_q.sp - 3'h1;  // see [RQ3]
        s_d.pc = stackPcIn;
      end
      IETU_OP_CALL, IETU_OP_JMP: begin
        if (opCode == IETU_OP_CALL) begin
          s_d.push = 1'b1;
          s_d.pushData = {s_q.cy, s_q.ac, s_q.work_bank_choice, s_q.pc};
          s_d.sp = s_q.sp + 3'h1;  // see [RQ23]
        end
        s_d.pc = {(s_q.interrupt_active_flag ? 2'b00 : s_q.bankLatch), jumpTarget};  // see [RQ1]
      end
      IETU_OP_BANKSEL: begin
        s_d.work_bank_choice = bankSelValue;  // see [RQ3]
      end
      default: begin
      end
    endcase
    // the serial/derivative line is level driven by its source
    extReq = s_q.extFlag && s_q.extEn;  // see [RQ6]
    serReq = !serialIrqN && s_q.serEn;  // see [RQ14]
    tmrReq = s_q.tmrFlag && s_q.tmrEn;
    if (instrBoundary && opCode == IETU_OP_NONE && !s_q.interrupt_active_flag && s_q.mainDone &&
        (extReq || serReq || tmrReq)) begin  // see [RQ24] [RQ4]
      if (extReq) begin  // see [RQ5]
        vec = `IETU_VEC_EXT;  // see [RQ8]
        s_d.extFlag = extEdge;  // an edge in the vector cycle stays pending
        s_d.extLatch = extEdge;
      end else if (serReq) begin
        vec = `IETU_VEC_SER;
      end else begin
        vec = `IETU_VEC_TMR;
        s_d.tmrFlag = ovf;  // an overflow in the vector cycle stays pending
      end
      s_d.push = 1'b1;
      s_d.pushData = {s_q.cy, s_q.ac, s_q.work_bank_choice, s_q.pc};  // see [RQ7]
      s_d.sp = s_q.sp + 3'h1;  // see [RQ23]
      s_d.pc = vec;  // see [RQ10]
      s_d.interrupt_active_flag = 1'b1;
      s_d.vcall = 1'b1;
    end
    if (testSelect != 3'h0) begin  // see [RQ13]
      s_d.brTaken = testPin(testSelect, irqTestAInput, countTestBInput, s_q.ovfFlag,
                            s_q.extEn) ^ testInvert;
      if (testSelect == 3'h1 && s_q.extEn) begin
        s_d.brTaken = 1'b0;
      end
      if (testSelect == 3'h3) begin
        s_d.ovfFlag = 1'b0;  // see [RQ22]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.mainDone <= 1'b1;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign programCounter      = s_q.pc;
  assign processorStatusWord = {s_q.cy, s_q.ac, 1'b1, s_q.work_bank_choice, s_q.ps, s_q.sp};  // see [RQ2]
  assign counterValue        = s_q.count;
  assign stackPush           = s_q.push;
  assign stackPushData       = s_q.pushData;
  assign stackLevel          = s_q.sp;
  assign vectorCall          = s_q.vcall;
  assign branchTaken         = s_q.brTaken;
  assign interruptActiveFlag = s_q.interrupt_active_flag;
  assign timerOverflowFlag   = s_q.ovfFlag;

  sequence s_take;
    vectorCall;
  endsequence

  property p_vec_bank0;
    @(posedge clk) disable iff (!resetn) s_take |-> programCounter[12:11] == 2'b00;
  endproperty
  a_vec_bank0: assert property (p_vec_bank0) else $error("vector left bank 0"); // see [RQ10]

  property p_vec_addr;
    @(posedge clk) disable iff (!resetn)
      s_take |-> (programCounter == 13'h0003 || programCounter == 13'h0005 ||
                  programCounter == 13'h0007);
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("bad vector"); // see [RQ8]

  property p_single;
    @(posedge clk) disable iff (!resetn)
      $past(interruptActiveFlag) && $past(clkEn) |-> !vectorCall;
  endproperty
  a_single: assert property (p_single) else $error("nested interrupt"); // see [RQ4]

  property p_push;
    @(posedge clk) disable iff (!resetn) s_take |-> stackPush && interruptActiveFlag;
  endproperty
  a_push: assert property (p_push) else $error("no push on vector"); // see [RQ7]

  property p_sp_inc;
    @(posedge clk) disable iff (!resetn)
      stackPush && $past(clkEn) |-> stackLevel == 3'($past(stackLevel) + 3'h1);
  endproperty
  a_sp_inc: assert property (p_sp_inc) else $error("stack level not advanced"); // see [RQ23]

  property p_psw_one;
    @(posedge clk) disable iff (!resetn) processorStatusWord[5];
  endproperty
  a_psw_one: assert property (p_psw_one) else $error("status bit 5 low"); // see [RQ2]

  property p_ovf_sticky;
    @(posedge clk) disable iff (!resetn)
      $past(timerOverflowFlag) && $past(testSelect) != 3'h3 |-> timerOverflowFlag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost"); // see [RQ22]

  property p_cstart;
    @(posedge clk) disable iff (!resetn)
      opCode == IETU_OP_CSTART && clkEn |=> counterValue == 8'hFF;
  endproperty
  a_cstart: assert property (p_cstart) else $error("event start not all ones"); // see [RQ16]

  property p_halt;
    @(posedge clk) disable iff (!resetn)
      opCode == IETU_OP_HALT && clkEn ##1 opCode == IETU_OP_NONE && !counterWrite
      |=> $stable(counterValue);
  endproperty
  a_halt: assert property (p_halt) else $error("counter runs after halt"); // see [RQ21]
endmodule : ietu_top

// ===== testbench/ietu_pin_source.sv
// far side model: external request pin, event count pin and shared request line
// every level changes just after a rising clk edge, off the sampling edge
module ietu_pin_source (
  input  wire logic clk,
  output logic      irqPin,
  output logic      cntPin,
  output logic      serialN
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    irqPin  = 1'b1;
    cntPin  = 1'b0;
    serialN = 1'b1;
  end
  // falling edge: high for hi clocks, low for lo clocks, then back high
  task automatic fall(input int hi, input int lo);
    irqPin <= 1'b1;
    repeat (hi) @(posedge clk);
    irqPin <= 1'b0;
    repeat (lo) @(posedge clk);
    irqPin <= 1'b1;
  endtask : fall
  // rising edge: low for lo clocks, high for hi clocks, then back low
  task automatic rise(input int lo, input int hi);
    cntPin <= 1'b0;
    repeat (lo) @(posedge clk);
    cntPin <= 1'b1;
    repeat (hi) @(posedge clk);
    cntPin <= 1'b0;
  endtask : rise
  task automatic level(input logic a, input logic b);
    irqPin <= a;
    cntPin <= b;
  endtask : level
  // low requests service, high once the routine removed the cause
  task automatic serial(input logic v);
    serialN <= v;
  endtask : serial
endmodule : ietu_pin_source

// ===== testbench/tb.sv
// self-checking bench of ietu_top with random and corner stimulus on the op interface
// assumes ietu_pin_source plays the pins; the bench plays the core and the stack memory
module tb
  import ietu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, resetn, clkEn, irqTestAInput, countTestBInput, serialIrqN;
  ietu_op_type opCode;
  logic        instrBoundary, pcIncrement, bankPreselect, pswWrite, counterWrite;
  logic        bankSelValue, addUpdate, halfCarryIn, carryIn, carryUpdate, testInvert;
  logic [10:0] jumpTarget;
  logic [1:0]  bankValue;
  logic [7:0]  accIn, counterValue, processorStatusWord, c0;
  logic [2:0]  testSelect, stackPswIn, stackLevel;
  logic [12:0] stackPcIn, programCounter;
  logic [15:0] stackPushData;
  logic        stackPush, vectorCall, branchTaken, interruptActiveFlag, timerOverflowFlag;
  logic [31:0] seed;
  int          fail_count, n_checks, cycles;

  ietu_pin_source u_pins (.clk(clk), .irqPin(irqTestAInput), .cntPin(countTestBInput),
    .serialN(serialIrqN));
  ietu_top u_dut (.clk(clk), .resetn(resetn), .clkEn(clkEn), .irqTestAInput(irqTestAInput),
    .countTestBInput(countTestBInput), .serialIrqN(serialIrqN), .opCode(opCode),
    .instrBoundary(instrBoundary), .pcIncrement(pcIncrement), .jumpTarget(jumpTarget),
    .bankPreselect(bankPreselect), .bankValue(bankValue), .pswWrite(pswWrite),
    .accIn(accIn), .counterWrite(counterWrite), .bankSelValue(bankSelValue),
    .addUpdate(addUpdate), .halfCarryIn(halfCarryIn), .carryIn(carryIn),
    .carryUpdate(carryUpdate), .testSelect(testSelect), .testInvert(testInvert),
    .stackPcIn(stackPcIn), .stackPswIn(stackPswIn), .programCounter(programCounter),
    .processorStatusWord(processorStatusWord), .counterValue(counterValue),
    .stackPush(stackPush), .stackPushData(stackPushData), .stackLevel(stackLevel),
    .vectorCall(vectorCall), .branchTaken(branchTaken),
    .interruptActiveFlag(interruptActiveFlag), .timerOverflowFlag(timerOverflowFlag));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic expBranch(input logic [2:0] sel, input logic inv,
                                     input logic pa, input logic pb, input logic tf);
    if (sel == 3'h0) return 1'b0;
    return ((sel == 3'h1) ? pa : (sel == 3'h2) ? pb : tf) ^ inv;
  endfunction : expBranch
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one op taken at the next edge; outputs are looked at just after it
  task automatic step(input ietu_op_type o);
    opCode <= o;
    @(posedge clk);
    opCode <= IETU_OP_NONE;
    #1;
  endtask : step
  task automatic bound();
    instrBoundary <= 1'b1;
    step(IETU_OP_NONE);
    instrBoundary <= 1'b0;
  endtask : bound
  task automatic vec(input logic [12:0] where);
    bound();
    check("vector", {vectorCall, stackPush, interruptActiveFlag}, 3'h7);
    check("vecpc", programCounter, where);
  endtask : vec
  task automatic wait_tf();
    for (int i = 0; i < 120 && timerOverflowFlag !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_tf
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    {fail_count, n_checks, cycles} = '0;
    seed = 32'h0000000C;
    {resetn, instrBoundary, pcIncrement, bankPreselect, pswWrite, counterWrite} = '0;
    {bankSelValue, addUpdate, halfCarryIn, carryIn, carryUpdate, testInvert} = '0;
    {jumpTarget, bankValue, accIn, testSelect, stackPcIn} = '0;
    stackPswIn = 3'h7;
    opCode = IETU_OP_NONE;
    clkEn = 1'b1;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    check("psw", processorStatusWord, 8'h20);
    check("pcrst", {programCounter, stackLevel}, 16'h0000);
    check("flags", {interruptActiveFlag, timerOverflowFlag, counterValue}, 10'h000);
    bankSelValue <= 1'b1;
    {addUpdate, halfCarryIn, carryUpdate, carryIn} <= 4'hF;
    step(IETU_OP_BANKSEL);
    {addUpdate, carryUpdate} <= 2'h0;
    check("pswbits", processorStatusWord, 8'hF0);
    seed = xs(seed);
    accIn <= seed[7:0];
    pswWrite <= 1'b1;
    step(IETU_OP_NONE);
    pswWrite <= 1'b0;
    check("pswps", processorStatusWord, {4'hF, seed[3], 3'h0});
    bankValue <= 2'h2;
    bankPreselect <= 1'b1;
    step(IETU_OP_NONE);
    bankPreselect <= 1'b0;
    check("pcpre", programCounter, 13'h0000);
    jumpTarget <= 11'h7FF;
    step(IETU_OP_JMP);
    check("pcjmp", programCounter, 13'h17FF);
    pcIncrement <= 1'b1;
    step(IETU_OP_NONE);
    pcIncrement <= 1'b0;
    check("pcwrap", programCounter, 13'h1000);
    for (int i = 0; i < 8; i++) step(IETU_OP_CALL);
    check("spwrap", stackLevel, 3'h0);
    for (int i = 0; i < 8; i++) step(IETU_OP_RET);
    check("spret", stackLevel, 3'h0);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      u_pins.level(seed[0], seed[1]);
      repeat (4) @(posedge clk);
      #1;
      testSelect <= 3'(i % 4);
      testInvert <= seed[2];
      step(IETU_OP_NONE);
      testSelect <= 3'h0;
      check("branch", branchTaken,
            expBranch(3'(i % 4), seed[2], seed[0], seed[1], 1'b0));
    end
    // top bit kept clear so the timer checks below never overflow the counter
    seed = xs(seed);
    accIn <= {1'b0, seed[14:8]};
    counterWrite <= 1'b1;
    step(IETU_OP_NONE);
    counterWrite <= 1'b0;
    check("cntwr", counterValue, {1'b0, seed[14:8]});
    accIn <= 8'h08;
    pswWrite <= 1'b1;
    step(IETU_OP_TSTART);
    pswWrite <= 1'b0;
    c0 = counterValue;
    repeat (300) @(posedge clk);
    #1;
    check("tmr1", counterValue, 8'(c0 + 8'h0A));
    clkEn <= 1'b0;
    repeat (60) @(posedge clk);
    #1;
    check("freeze", counterValue, 8'(c0 + 8'h0A));
    clkEn <= 1'b1;
    accIn <= 8'h00;
    pswWrite <= 1'b1;
    step(IETU_OP_NONE);
    pswWrite <= 1'b0;
    step(IETU_OP_TSTART);
    c0 = counterValue;
    repeat (930) @(posedge clk);
    #1;
    check("tmrclr", counterValue, c0);
    repeat (60) @(posedge clk);
    #1;
    check("tmr32", counterValue, 8'(c0 + 8'h01));
    step(IETU_OP_HALT);
    c0 = counterValue;
    repeat (100) @(posedge clk);
    #1;
    check("halt", counterValue, c0);
    step(IETU_OP_TMR_EN);
    step(IETU_OP_CSTART);
    check("cstart", counterValue, 8'hFF);
    u_pins.rise(2, 2);
    repeat (70) @(posedge clk);
    #1;
    check("short", counterValue, 8'hFF);
    u_pins.rise(8, 8);
    wait_tf();
    check("ovf", {timerOverflowFlag, counterValue}, 9'h100);
    vec(13'h0007);
    // carry, half carry and bank bit are all one here; pc was restored to zero
    check("push", stackPushData, 16'hE000);
    testSelect <= 3'h3;
    testInvert <= 1'b0;
    step(IETU_OP_NONE);
    testSelect <= 3'h0;
    check("jtf", {branchTaken, timerOverflowFlag}, 2'h2);
    step(IETU_OP_SER_EN);
    u_pins.serial(1'b0);
    repeat (3) @(posedge clk);
    bound();
    check("nopre", vectorCall, 1'b0);
    stackPcIn <= 13'h1000;
    step(IETU_OP_INTERRUPT_EXIT_OP);
    check("interrupt_exit_op", {interruptActiveFlag, stackLevel, programCounter}, 17'h01000);
    bound();
    check("onemain", vectorCall, 1'b0);
    vec(13'h0005);
    u_pins.serial(1'b1);
    step(IETU_OP_INTERRUPT_EXIT_OP);
    bound();
    bound();
    step(IETU_OP_EXT_DIS);
    step(IETU_OP_EXT_EN);
    u_pins.serial(1'b0);
    u_pins.fall(8, 12);
    repeat (4) @(posedge clk);
    instrBoundary <= 1'b1;
    step(IETU_OP_SER_EN);
    instrBoundary <= 1'b0;
    check("busy", vectorCall, 1'b0);
    vec(13'h0003);
    step(IETU_OP_INTERRUPT_EXIT_OP);
    bound();
    vec(13'h0005);
    jumpTarget <= 11'h055;
    step(IETU_OP_JMP);
    check("bank0", programCounter, 13'h0055);
    u_pins.serial(1'b1);
    step(IETU_OP_INTERRUPT_EXIT_OP);
    bound();
    u_pins.level(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    #1;
    testSelect <= 3'h1;
    step(IETU_OP_NONE);
    testSelect <= 3'h0;
    check("t0ext", branchTaken, 1'b0);
    u_pins.fall(8, 12);
    repeat (4) @(posedge clk);
    step(IETU_OP_EXT_DIS);
    step(IETU_OP_EXT_EN);
    bound();
    check("extdis", vectorCall, 1'b0);
    step(IETU_OP_CSTART);
    u_pins.rise(8, 8);
    wait_tf();
    step(IETU_OP_TMR_DIS);
    bound();
    check("tmrdis", {timerOverflowFlag, vectorCall}, 2'h2);
    stop_test();
  end
endmodule : tb
